// ===== lfk_pkg.sv
package lfk_pkg;

  // ****************************************
  // bus and storage widths
  // ****************************************
  localparam int AW    = 12;
  localparam int DW    = 32;
  localparam int RW    = 16;
  localparam int XW    = AW - 2;
  localparam int NSLOT = 21;
  localparam int SW    = 5;

  // ****************************************
  // register indices (byte address = 4 x index)
  // ****************************************
  localparam logic [XW-1:0] IX_CM_MAX   = 10'h01f;
  localparam logic [XW-1:0] IX_PWR_A    = 10'h020;
  localparam logic [XW-1:0] IX_PWR_B    = 10'h021;
  localparam logic [XW-1:0] IX_PWR_C    = 10'h022;
  localparam logic [XW-1:0] IX_LC_FILT  = 10'h023;
  localparam logic [XW-1:0] IX_RT_FILT  = 10'h024;
  localparam logic [XW-1:0] IX_POLE_A   = 10'h025;
  localparam logic [XW-1:0] IX_POLE_B   = 10'h026;
  localparam logic [XW-1:0] IX_POLE_C   = 10'h027;
  localparam logic [XW-1:0] IX_CM_BIAS  = 10'h028;
  localparam logic [XW-1:0] IX_OV_VOLT  = 10'h029;
  localparam logic [XW-1:0] IX_RSVD     = 10'h02a;
  localparam logic [XW-1:0] IX_LC_LOWER = 10'h02b;
  localparam logic [XW-1:0] IX_SP_AMP   = 10'h063;
  localparam logic [XW-1:0] IX_SP_FREQ  = 10'h064;
  localparam logic [XW-1:0] IX_MK_AMP   = 10'h065;
  localparam logic [XW-1:0] IX_MK_FREQ  = 10'h066;
  localparam logic [XW-1:0] IX_S2M_GAIN = 10'h067;
  localparam logic [XW-1:0] IX_M2S_GAIN = 10'h068;
  localparam logic [XW-1:0] IX_CTRL_LC  = 10'h06c;
  localparam logic [XW-1:0] IX_CTRL_OSC = 10'h070;
  localparam logic [XW-1:0] IX_STATUS   = 10'h071;

  // ****************************************
  // storage slots
  // ****************************************
  localparam logic [SW-1:0] SL_CM    = 5'h00;
  localparam logic [SW-1:0] SL_PWR_A = 5'h01;
  localparam logic [SW-1:0] SL_LCF   = 5'h04;
  localparam logic [SW-1:0] SL_RTF   = 5'h05;
  localparam logic [SW-1:0] SL_POLE  = 5'h06;
  localparam logic [SW-1:0] SL_BIAS  = 5'h09;
  localparam logic [SW-1:0] SL_OV    = 5'h0a;
  localparam logic [SW-1:0] SL_RSVD  = 5'h0b;
  localparam logic [SW-1:0] SL_LCL   = 5'h0c;
  localparam logic [SW-1:0] SL_FSK   = 5'h0d;
  localparam logic [SW-1:0] SL_CLC   = 5'h13;
  localparam logic [SW-1:0] SL_COSC  = 5'h14;
  localparam logic [SW-1:0] SL_STAT  = 5'h15;

  // ****************************************
  // field positions and widths
  // ****************************************
  localparam int B_HYS_EN   = 0;
  localparam int B_FSK_EN   = 6;
  localparam int B_REL_EN   = 6;
  localparam int B_OV_RANGE = 4;
  localparam int W_CM       = 6;
  localparam int W_PWR      = 8;
  localparam int W_LC       = 6;
  localparam int W_OV       = 4;
  localparam int S_WIDE     = 0;
  localparam int S_LOOP     = 1;
  localparam int S_ALARM    = 2;
  localparam int S_ENH      = 5;
  localparam int S_BIT      = 6;
  localparam logic RST_LAST_BIT = 1'b1;

endpackage

// ===== lfk_fsk_reload.sv
`timescale 1ns/1ps
module lfk_fsk_reload (
  input  wire logic                     i_clock,
  input  wire logic                     i_resetn,
  input  wire logic                     i_fsk_en,
  input  wire logic                     i_rel_en,
  input  wire logic                     i_expire,
  input  wire logic                     i_bit,
  input  wire logic [lfk_pkg::RW-1:0]   i_osc_amp,
  input  wire logic [lfk_pkg::RW-1:0]   i_osc_freq,
  input  wire logic [lfk_pkg::RW-1:0]   i_sp_amp,
  input  wire logic [lfk_pkg::RW-1:0]   i_sp_freq,
  input  wire logic [lfk_pkg::RW-1:0]   i_mk_amp,
  input  wire logic [lfk_pkg::RW-1:0]   i_mk_freq,
  input  wire logic [lfk_pkg::RW-1:0]   i_s2m,
  input  wire logic [lfk_pkg::RW-1:0]   i_m2s,
  output logic                          o_load,
  output logic [lfk_pkg::RW-1:0]        o_amp,
  output logic [lfk_pkg::RW-1:0]        o_freq,
  output logic                          o_gain_apply,
  output logic [lfk_pkg::RW-1:0]        o_gain,
  output logic                          o_last_bit,
  output logic                          o_enh
);
  import lfk_pkg::*;

  typedef struct packed {
    logic          load;
    logic [RW-1:0] amp;
    logic [RW-1:0] freq;
    logic          gapply;
    logic [RW-1:0] gain;
    logic          last;
    logic          enh;
  } lfk_fsk_st_t;

  lfk_fsk_st_t s_reg;
  lfk_fsk_st_t s_next;
  logic        enh;

  // ****************************************
  // reload selection
  // ****************************************
  // enhanced mode needs both enables
  assign enh = i_fsk_en & i_rel_en;

  // bit is sampled at the expiry pulse only
  always_comb begin
    s_next        = s_reg;
    s_next.load   = i_expire;
    s_next.gapply = 1'b0;
    s_next.enh    = enh;
    if (i_expire) begin
      if (enh) begin
        s_next.amp  = i_bit ? i_mk_amp : i_sp_amp;
        s_next.freq = i_bit ? i_mk_freq : i_sp_freq;
        s_next.last = i_bit;
        // gain correction only on a change of symbol
        if (i_bit && !s_reg.last) begin
          s_next.gapply = 1'b1;
          s_next.gain   = i_s2m;
        end else if (!i_bit && s_reg.last) begin
          s_next.gapply = 1'b1;
          s_next.gain   = i_m2s;
        end
      end else begin
        s_next.amp  = i_osc_amp;
        s_next.freq = i_osc_freq;
      end
    end
  end

  // last bit idles at mark so a leading mark run is not corrected
  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      s_reg      <= '0;
      s_reg.last <= RST_LAST_BIT;
    end else begin
      s_reg <= s_next;
    end
  end

  assign o_load       = s_reg.load;
  assign o_amp        = s_reg.amp;
  assign o_freq       = s_reg.freq;
  assign o_gain_apply = s_reg.gapply;
  assign o_gain       = s_reg.gain;
  assign o_last_bit   = s_reg.last;
  assign o_enh        = s_reg.enh;

  // ****************************************
  // checks
  // ****************************************
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_resetn);

  normal_load_a: assert property (i_expire && !(i_fsk_en && i_rel_en) |=> o_load && o_amp == $past(i_osc_amp)
    && o_freq == $past(i_osc_freq)) else $error("normal reload wrong");
  space_amp_a: assert property (i_expire && enh && !i_bit |=> o_amp == $past(i_sp_amp))
    else $error("space amplitude not loaded");
  space_freq_a: assert property (i_expire && enh && !i_bit |=> o_freq == $past(i_sp_freq))
    else $error("space frequency not loaded");
  mark_amp_a: assert property (i_expire && enh && i_bit |=> o_amp == $past(i_mk_amp))
    else $error("mark amplitude not loaded");
  mark_freq_a: assert property (i_expire && enh && i_bit |=> o_freq == $past(i_mk_freq))
    else $error("mark frequency not loaded");
  gain_s2m_a: assert property (i_expire && enh && i_bit && !o_last_bit |=> o_gain_apply && o_gain == $past(i_s2m))
    else $error("space to mark gain missing");
  gain_m2s_a: assert property (i_expire && enh && !i_bit && o_last_bit |=> o_gain_apply && o_gain == $past(i_m2s))
    else $error("mark to space gain missing");
  gain_quiet_a: assert property (!i_expire |=> !o_gain_apply) else $error("gain applied without expiry");
  fsk_toggle_c: cover property (i_expire && enh && i_bit ##[1:50] i_expire && enh && !i_bit);
endmodule

// ===== lfk_linefeed_regs.sv
// Chosen here: register access over APB.
`timescale 1ns/1ps
// How it works
// - line speeds up its dc loop when common-mode voltage passes the max threshold
// - three power alarm thresholds, one per transistor pair, own addresses
// - loop closure and ring trip filter coefficients sit in separate registers
// - each transistor pair gets its own thermal filter pole
// - a 4-bit overhead code sets the converter overhead voltage
// - with hysteresis on, loop release uses the separate lower threshold
// - enhanced FSK only when both enable bits are set
// - space expiry loads space amplitude in place of normal amplitude
// - space expiry loads space frequency in place of normal frequency
// - mark expiry loads mark amplitude in place of normal amplitude
// - mark expiry loads mark frequency in place of normal frequency
// - space to mark change applies the space-to-mark gain factor
// - mark to space change applies the mark-to-space gain factor
module lfk_linefeed_regs (
  input  wire logic                                i_clock,
  input  wire logic                                i_resetn,
  // apb slave
  input  wire logic                                i_psel,
  input  wire logic                                i_penable,
  input  wire logic                                i_pwrite,
  input  wire logic [lfk_pkg::AW-1:0]              i_paddr,
  input  wire logic [lfk_pkg::DW-1:0]              i_pwdata,
  output logic [lfk_pkg::DW-1:0]                   o_prdata,
  output logic                                     o_pready,
  output logic                                     o_pslverr,
  // linefeed side
  input  wire logic [lfk_pkg::W_CM-1:0]            i_cm_voltage,
  input  wire logic [2:0][lfk_pkg::W_PWR-1:0]      i_pair_power,
  input  wire logic [lfk_pkg::W_LC-1:0]            i_loop_current,
  input  wire logic [lfk_pkg::W_LC-1:0]            i_lc_upper_thr,
  output logic                                     o_wide_bandwidth,
  output logic [2:0]                               o_power_alarm,
  output logic                                     o_loop_closed,
  output logic [lfk_pkg::RW-1:0]                   o_lc_filter_coef,
  output logic [lfk_pkg::RW-1:0]                   o_rt_filter_coef,
  output logic [2:0][lfk_pkg::RW-1:0]              o_thermal_pole,
  output logic [lfk_pkg::RW-1:0]                   o_cm_bias_adjust,
  output logic [lfk_pkg::W_OV-1:0]                 o_overhead_voltage_code,
  output logic                                     o_overhead_range_select,
  // tone oscillator 1 side
  input  wire logic                                i_frequency_coef_a_timer_expire,
  input  wire logic                                i_fsk_bit,
  input  wire logic [lfk_pkg::RW-1:0]              i_frequency_coef_a_amplitude_coef,
  input  wire logic [lfk_pkg::RW-1:0]              i_frequency_coef_a,
  output logic                                     o_frequency_coef_a_load,
  output logic [lfk_pkg::RW-1:0]                   o_frequency_coef_a_load_amp,
  output logic [lfk_pkg::RW-1:0]                   o_frequency_coef_a_load_freq,
  output logic                                     o_gain_apply,
  output logic [lfk_pkg::RW-1:0]                   o_gain_corr
);
  import lfk_pkg::*;

  typedef struct packed {
    logic [NSLOT-1:0][RW-1:0] rg;
    logic [DW-1:0]            prdata;
    logic                     pready;
    logic                     pslverr;
    logic                     wide;
    logic [2:0]               alarm;
    logic                     loop;
  } lfk_top_st_t;

  lfk_top_st_t    s_reg;
  lfk_top_st_t    s_next;
  logic [SW:0]    dec;
  logic           hit;
  logic [SW-1:0]  slot;
  logic           setup;
  logic           wr_done;
  logic [2:0]     pair_over;
  logic [W_LC-1:0] lower_thr;
  logic           hys_en;
  logic           fsk_last;
  logic           fsk_enh;
  logic [RW-1:0]  status;

  // ****************************************
  // address decode
  // ****************************************
  // returns {hit, slot}; used for read and write paths
  function automatic logic [SW:0] slot_of(input logic [AW-1:0] a);
    logic [XW-1:0] ix;
    logic [SW:0]   r;
    ix = a[AW-1:2];
    r  = '0;
    if (ix >= IX_CM_MAX && ix <= IX_LC_LOWER) begin
      r = {1'b1, SW'(ix - IX_CM_MAX)};
    end else if (ix >= IX_SP_AMP && ix <= IX_M2S_GAIN) begin
      r = {1'b1, SW'(ix - IX_SP_AMP) + SL_FSK};
    end else if (ix == IX_CTRL_LC) begin
      r = {1'b1, SL_CLC};
    end else if (ix == IX_CTRL_OSC) begin
      r = {1'b1, SL_COSC};
    end else if (ix == IX_STATUS) begin
      r = {1'b1, SL_STAT};
    end
    return r;
  endfunction

  // unaligned low address bits are ignored
  assign dec     = slot_of(i_paddr);
  assign hit     = dec[SW];
  assign slot    = dec[SW-1:0];
  assign setup   = i_psel & ~i_penable;
  assign wr_done = i_psel & i_penable & s_reg.pready & i_pwrite;

  // ****************************************
  // linefeed comparators
  // ****************************************
  // one alarm comparator per transistor pair
  genvar k;
  generate
    for (k = 0; k < 3; k++) begin : g_pair
      assign pair_over[k] = i_pair_power[k] > s_reg.rg[SL_PWR_A + SW'(k)][W_PWR-1:0];
      assign o_thermal_pole[k] = s_reg.rg[SL_POLE + SW'(k)];
    end
  endgenerate

  // hysteresis moves the release point down to the lower bound
  assign hys_en    = s_reg.rg[SL_CLC][B_HYS_EN];
  assign lower_thr = hys_en ? s_reg.rg[SL_LCL][W_LC-1:0] : i_lc_upper_thr;

  // status view of the block's own state
  always_comb begin
    status                      = '0;
    status[S_WIDE]              = s_reg.wide;
    status[S_LOOP]              = s_reg.loop;
    status[S_ALARM +: 3]        = s_reg.alarm;
    status[S_ENH]               = fsk_enh;
    status[S_BIT]               = fsk_last;
  end

  // ****************************************
  // next state
  // ****************************************
  // pready rises one cycle after setup: access phase is one cycle
  always_comb begin
    s_next         = s_reg;
    s_next.pready  = setup;
    s_next.pslverr = 1'b0;
    if (setup) begin
      s_next.pslverr = ~hit;
      s_next.prdata  = '0;
      if (hit && slot == SL_STAT) begin
        s_next.prdata[RW-1:0] = status;
      end else if (hit && slot != SL_RSVD) begin
        s_next.prdata[RW-1:0] = s_reg.rg[slot];
      end
    end
    // write lands at the access edge; reserved and status ignore it
    if (wr_done && hit && slot != SL_RSVD && slot != SL_STAT) begin
      s_next.rg[slot] = i_pwdata[RW-1:0];
    end
    s_next.wide  = i_cm_voltage > s_reg.rg[SL_CM][W_CM-1:0];
    s_next.alarm = pair_over;
    // closure sets above upper bound, clears below release point
    if (!s_reg.loop && i_loop_current > i_lc_upper_thr) begin
      s_next.loop = 1'b1;
    end else if (s_reg.loop && i_loop_current < lower_thr) begin
      s_next.loop = 1'b0;
    end
  end

  // register contents are cleared here; software must still program them
  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // ****************************************
  // oscillator 1 reload
  // ****************************************
  lfk_fsk_reload u_fsk (
    .i_clock      (i_clock),
    .i_resetn     (i_resetn),
    .i_fsk_en     (s_reg.rg[SL_CLC][B_FSK_EN]),
    .i_rel_en     (s_reg.rg[SL_COSC][B_REL_EN]),
    .i_expire     (i_frequency_coef_a_timer_expire),
    .i_bit        (i_fsk_bit),
    .i_osc_amp    (i_frequency_coef_a_amplitude_coef),
    .i_osc_freq   (i_frequency_coef_a),
    .i_sp_amp     (s_reg.rg[SL_FSK]),
    .i_sp_freq    (s_reg.rg[SL_FSK + SW'(1)]),
    .i_mk_amp     (s_reg.rg[SL_FSK + SW'(2)]),
    .i_mk_freq    (s_reg.rg[SL_FSK + SW'(3)]),
    .i_s2m        (s_reg.rg[SL_FSK + SW'(4)]),
    .i_m2s        (s_reg.rg[SL_FSK + SW'(5)]),
    .o_load       (o_frequency_coef_a_load),
    .o_amp        (o_frequency_coef_a_load_amp),
    .o_freq       (o_frequency_coef_a_load_freq),
    .o_gain_apply (o_gain_apply),
    .o_gain       (o_gain_corr),
    .o_last_bit   (fsk_last),
    .o_enh        (fsk_enh)
  );

  // ****************************************
  // outputs
  // ****************************************
  // all straight from flip-flops
  assign o_prdata                = s_reg.prdata;
  assign o_pready                = s_reg.pready;
  assign o_pslverr               = s_reg.pslverr;
  assign o_wide_bandwidth        = s_reg.wide;
  assign o_power_alarm           = s_reg.alarm;
  assign o_loop_closed           = s_reg.loop;
  assign o_lc_filter_coef        = s_reg.rg[SL_LCF];
  assign o_rt_filter_coef        = s_reg.rg[SL_RTF];
  // bias adjust passes through; writing zero is left to software
  assign o_cm_bias_adjust        = s_reg.rg[SL_BIAS];
  // code is not clamped; range per select bit is software's duty
  assign o_overhead_voltage_code = s_reg.rg[SL_OV][W_OV-1:0];
  assign o_overhead_range_select = s_reg.rg[SL_COSC][B_OV_RANGE];

  // ****************************************
  // checks
  // ****************************************
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_resetn);

  apb_ready_a: assert property (setup |=> o_pready ##1 !o_pready) else $error("pready not one cycle");
  apb_unmapped_a: assert property (setup && !hit |=> o_pslverr && o_prdata == '0)
    else $error("unmapped access not flagged");
  wide_bw_a: assert property (##1 o_wide_bandwidth == $past(i_cm_voltage > s_reg.rg[SL_CM][W_CM-1:0]))
    else $error("speed-up compare wrong");
  pair_alarm_a: assert property (i_pair_power[1] > s_reg.rg[SL_PWR_A + SW'(1)][W_PWR-1:0] |=> o_power_alarm[1])
    else $error("pair alarm missed");
  filt_write_a: assert property (wr_done && i_paddr[AW-1:2] == IX_LC_FILT
    |=> o_lc_filter_coef == $past(i_pwdata[RW-1:0]) && o_rt_filter_coef == $past(o_rt_filter_coef))
    else $error("filter coefficient write wrong");
  ov_write_a: assert property (wr_done && i_paddr[AW-1:2] == IX_OV_VOLT
    |=> o_overhead_voltage_code == $past(i_pwdata[W_OV-1:0])) else $error("overhead code write wrong");
  loop_hys_a: assert property (o_loop_closed && hys_en && i_loop_current >= s_reg.rg[SL_LCL][W_LC-1:0]
    |=> o_loop_closed) else $error("loop released above lower bound");
  rsvd_read_a: assert property (setup && !i_pwrite && i_paddr[AW-1:2] == IX_RSVD
    |=> o_prdata == '0 && !o_pslverr) else $error("reserved slot not inert");
  enh_mode_a: assert property (s_reg.rg[SL_CLC][B_FSK_EN] && s_reg.rg[SL_COSC][B_REL_EN] |=> fsk_enh)
    else $error("enhanced mode not entered");
  wide_rise_c: cover property (!o_wide_bandwidth ##1 o_wide_bandwidth);
  loop_cycle_c: cover property (o_loop_closed ##[1:100] !o_loop_closed);
  write_read_c: cover property (wr_done ##[1:10] setup && !i_pwrite);
endmodule

// ===== test_lfk_linefeed_regs.sv
`timescale 1ns/1ps
module test_lfk_linefeed_regs;
  import lfk_pkg::*;
  // ********
  // bench signals
  // ********
  logic                  i_clock = 1'b0;
  logic                  i_resetn = 1'b0;
  logic                  psel = 1'b0;
  logic                  penable = 1'b0;
  logic                  pwrite = 1'b0;
  logic [AW-1:0]         paddr = '0;
  logic [DW-1:0]         pwdata = '0;
  logic [DW-1:0]         prdata;
  logic                  pready;
  logic                  pslverr;
  logic [W_CM-1:0]       cm = '0;
  logic [2:0][W_PWR-1:0] pwr = '0;
  logic [W_LC-1:0]       cur = '0;
  logic [W_LC-1:0]       upth = '0;
  logic                  wide;
  logic [2:0]            alarm;
  logic                  closed;
  logic [RW-1:0]         lcf;
  logic [RW-1:0]         rtf;
  logic [2:0][RW-1:0]    pole;
  logic [RW-1:0]         bias;
  logic [W_OV-1:0]       ovc;
  logic                  ovr;
  logic                  expire = 1'b0;
  logic                  fbit = 1'b0;
  logic [RW-1:0]         namp = '0;
  logic [RW-1:0]         nfreq = '0;
  logic                  load;
  logic [RW-1:0]         lamp;
  logic [RW-1:0]         lfreq;
  logic                  gapp;
  logic [RW-1:0]         gain;
  integer                seed = 32'h4593;
  int                    err_count = 0;
  int                    samples_checked = 0;
  int                    t;
  logic                  last;
  logic                  b;
  logic [DW-1:0]         rd;
  logic                  er;
  logic [RW-1:0]         mem [19];
  logic [XW-1:0]         ix [19] = '{IX_CM_MAX, IX_PWR_A, IX_PWR_B, IX_PWR_C, IX_LC_FILT, IX_RT_FILT, IX_POLE_A,
    IX_POLE_B, IX_POLE_C, IX_CM_BIAS, IX_OV_VOLT, IX_RSVD, IX_LC_LOWER, IX_SP_AMP, IX_SP_FREQ, IX_MK_AMP,
    IX_MK_FREQ, IX_S2M_GAIN, IX_M2S_GAIN};
  logic [W_LC-1:0]       cv [5] = '{6'h1f, 6'h14, 6'h05, 6'h1f, 6'h14};
  logic                  ce [5] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0};

  // free-running 125 MHz clock
  always #4 i_clock = ~i_clock;

  lfk_linefeed_regs lfk_linefeed_regs_inst (
    .i_clock(i_clock), .i_resetn(i_resetn), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_cm_voltage(cm), .i_pair_power(pwr), .i_loop_current(cur), .i_lc_upper_thr(upth),
    .o_wide_bandwidth(wide), .o_power_alarm(alarm), .o_loop_closed(closed), .o_lc_filter_coef(lcf),
    .o_rt_filter_coef(rtf), .o_thermal_pole(pole), .o_cm_bias_adjust(bias), .o_overhead_voltage_code(ovc),
    .o_overhead_range_select(ovr), .i_frequency_coef_a_timer_expire(expire), .i_fsk_bit(fbit),
    .i_frequency_coef_a_amplitude_coef(namp), .i_frequency_coef_a(nfreq), .o_frequency_coef_a_load(load), .o_frequency_coef_a_load_amp(lamp),
    .o_frequency_coef_a_load_freq(lfreq), .o_gain_apply(gapp), .o_gain_corr(gain));

  // ********
  // shared tasks
  // ********
  task chk(input string nm, input logic [DW-1:0] seen, input logic [DW-1:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task results;
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // one apb transfer; upper data bits random since only the low half is kept
  task apb(input logic w, input logic [XW-1:0] x, input logic [RW-1:0] d);
    int n;
    n = 0;
    @(posedge i_clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {x, 2'b00};
    pwdata <= {16'($random(seed)), d};
    @(posedge i_clock);
    penable <= 1'b1;
    do begin
      @(posedge i_clock);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    if (n >= 20) err_count++;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // two edges let the registered compare land before it is looked at
  task step;
    repeat (2) @(posedge i_clock);
    #1;
  endtask

  // one timer expiry, then the load pulse is checked in its single cycle
  task fsk(input logic bt, input logic [RW-1:0] ea, input logic [RW-1:0] ef, input logic ga,
           input logic [RW-1:0] eg);
    @(posedge i_clock);
    expire <= 1'b1;
    fbit <= bt;
    @(posedge i_clock);
    expire <= 1'b0;
    fbit <= ~bt;
    #1;
    chk("load", load, 1);
    chk("load amp", lamp, ea);
    chk("load freq", lfreq, ef);
    chk("gain apply", gapp, ga);
    if (ga) chk("gain", gain, eg);
  endtask

  // ********
  // main sequence
  // ********
  initial begin
    repeat (10) @(posedge i_clock);
    i_resetn <= 1'b1;
    // all 19 data slots are programmed before anything relies on them; overhead code kept in range
    for (int i = 0; i < 19; i++) begin
      mem[i] = (i == 10) ? 16'({$random(seed)} % 7) : 16'($random(seed));
      apb(1'b1, ix[i], mem[i]);
    end
    for (int i = 0; i < 19; i++) begin
      apb(1'b0, ix[i], 16'h0000);
      chk("readback", rd, (i == 11) ? 32'h0 : {16'h0, mem[i]});
    end
    apb(1'b1, 10'h3ff, 16'h1234);
    chk("unmapped write error", er, 1);
    apb(1'b0, 10'h3ff, 16'h0000);
    chk("unmapped read", {er, rd[30:0]}, 32'h80000000);
    chk("loop filter", lcf, mem[4]);
    chk("ring trip filter", rtf, mem[5]);
    for (int i = 0; i < 3; i++) chk("thermal pole", pole[i], mem[6+i]);
    chk("cm bias", bias, mem[9]);
    // storage proven above; now leave the bias adjust at its recommended zero
    apb(1'b1, IX_CM_BIAS, 16'h0000);
    #1;
    chk("cm bias zero", bias, 16'h0);
    chk("overhead code", ovc, mem[10][3:0]);
    // speed-up threshold, just over and exactly at the boundary
    t = {$random(seed)} % 63;
    apb(1'b1, IX_CM_MAX, 16'(t));
    @(posedge i_clock);
    cm <= 6'(t + 1);
    step;
    chk("wide over", wide, 1);
    @(posedge i_clock);
    cm <= 6'(t);
    step;
    chk("wide at", wide, 0);
    // middle pair sits exactly at its threshold, so only outer pairs alarm
    for (int i = 0; i < 3; i++) begin
      t = {$random(seed)} % 255;
      apb(1'b1, XW'(IX_PWR_A + i), 16'(t));
      pwr[i] <= 8'(t + ((i != 1) ? 1 : 0));
    end
    step;
    chk("power alarm", alarm, 3'b101);
    // hysteresis on, then off: the middle current tells the bounds apart
    upth <= 6'h1e;
    apb(1'b1, IX_LC_LOWER, 16'h000a);
    apb(1'b1, IX_CTRL_LC, 16'h0041);
    for (int k = 0; k < 5; k++) begin
      if (k == 3) apb(1'b1, IX_CTRL_LC, 16'h0040);
      @(posedge i_clock);
      cur <= cv[k];
      step;
      chk("loop closed", closed, ce[k]);
    end
    // enhanced mode, hand-picked transitions then a random bit stream
    apb(1'b1, IX_CTRL_OSC, 16'h0050);
    // the write lands at the edge the task returns on; look once it has settled
    #1;
    chk("range select", ovr, 1);
    fsk(1'b1, mem[15], mem[16], 1'b0, 16'h0);
    fsk(1'b0, mem[13], mem[14], 1'b1, mem[18]);
    fsk(1'b1, mem[15], mem[16], 1'b1, mem[17]);
    last = 1'b1;
    for (int k = 0; k < 12; k++) begin
      b = 1'($random(seed));
      fsk(b, b ? mem[15] : mem[13], b ? mem[16] : mem[14], b != last, b ? mem[17] : mem[18]);
      last = b;
    end
    // reload enable off: normal coefficients, no gain step
    namp <= 16'($random(seed));
    nfreq <= 16'($random(seed));
    apb(1'b1, IX_CTRL_OSC, 16'h0010);
    fsk(1'b0, namp, nfreq, 1'b0, 16'h0);
    // status: last bit kept, enhanced off, outer alarms, no speed-up, loop open
    apb(1'b0, IX_STATUS, 16'h0000);
    chk("status error", er, 0);
    chk("status", rd, {25'h0, last, 1'b0, 3'b101, 2'b00});
    results;
  end

  // watchdog well beyond the few hundred cycles the sequence needs
  initial begin
    repeat (20000) @(posedge i_clock);
    err_count++;
    results;
  end
endmodule
